// ---- src/sdf_consts.svh ----
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH

// Datapath widths
`define SDF_ACC_W          32
`define SDF_OUT_W          36
`define SDF_CTR_W          14
`define SDF_CTRL_W         13
`define SDF_SETTLE_W       16

// Register word indices (byte address is index times four)
`define SDF_IDX_CTRL       2'h0
`define SDF_IDX_STATUS     2'h1
`define SDF_IDX_DATA       2'h2

// Control register fields
`define SDF_CTRL_RATIO_MSB 2
`define SDF_CTRL_RATIO_LSB 0
`define SDF_CTRL_TURBO     3
`define SDF_CTRL_PWR_MSB   5
`define SDF_CTRL_PWR_LSB   4
`define SDF_CTRL_ENABLE    6
`define SDF_CTRL_INSEL_MSB 8
`define SDF_CTRL_INSEL_LSB 7
`define SDF_CTRL_GAIN_MSB  11
`define SDF_CTRL_GAIN_LSB  9
`define SDF_CTRL_RESYNC    12
`define SDF_CTRL_RESET     13'h0043

// Status register fields
`define SDF_STAT_SINC3     0
`define SDF_STAT_SETTLED   1
`define SDF_STAT_READY_N   2
`define SDF_STAT_CHAN_MSB  4
`define SDF_STAT_CHAN_LSB  3
`define SDF_STAT_LG_MSB    19
`define SDF_STAT_LG_LSB    16

// Ratio as a power of two
`define SDF_LG_TURBO       4'h6
`define SDF_LG_BASE        4'h7
`define SDF_LG_SINC3_MAX   4'ha

// Modulator tick on one phase of the divide-by-two
`define SDF_MOD_TICK_PHASE 1'b1

// Settling times in master clock periods
`define SDF_SETTLE_64      16'h02d8
`define SDF_SETTLE_128     16'h0358
`define SDF_SETTLE_256     16'h0458
`define SDF_SETTLE_512     16'h0658
`define SDF_SETTLE_1024    16'h0a58

`endif

// ---- src/sdf_decim_filter.sv ----
`timescale 1ns/1ps
`include "sdf_consts.svh"

// How it works
// - Modulator clock is master clock halved
// - Sinc averaging filter, then decimate
// - Output rate is modulator rate over ratio
// - Ratio from 3-bit field; turbo forces 64
// - Nine ratios, 64 through 16384
// - Bit-stream feeds sinc3 and fast path together
// - Fast first-order path used after reset
// - Sinc3 path after two conversions, until reset
// - Ratios up to 1024: sinc3 output direct
// - Above 1024: sinc3 at 1024, then sinc1
// - Enable, input, gain or resync restarts settling
// - Unsettled samples still presented and flagged ready
// - Settling intervals per ratio, master clock periods
// - One independent filter instance per channel
// - Two-bit power level field selects mode
module sdf_decim_filter #(
    parameter logic [1:0]               CHAN_ID     = 2'h0,
    parameter logic [`SDF_SETTLE_W-1:0] SETTLE_2048 = 16'h1258,
    parameter logic [`SDF_SETTLE_W-1:0] SETTLE_4096 = 16'h2258,
    parameter logic [`SDF_SETTLE_W-1:0] SETTLE_8192 = 16'h4258,
    parameter logic [`SDF_SETTLE_W-1:0] SETTLE_16K  = 16'h8258
) (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  modBit,
    output      logic                  modClk,
    input  wire logic [3:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic                  wb_we_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    output      logic [31:0]           wb_dat_o,
    output      logic                  wb_ack_o,
    output      logic [`SDF_OUT_W-1:0] sampleOut,
    output      logic                  newSample,
    output      logic                  sampleReadyN,
    output      logic                  sinc3Active,
    output      logic                  settled,
    output      logic [1:0]            powerLevel
);
    sdf_pkg::sdf_state_type s_r;
    sdf_pkg::sdf_state_type s_nxt;

    logic [`SDF_OUT_W-1:0] fastSum;
    logic                  fastStrobe;
    logic [`SDF_OUT_W-1:0] postSum;
    logic                  postStrobe;
    logic                  clearAll;
    logic                  modTick;
    logic [3:0]            lgRatio;
    logic [3:0]            lgSinc3;
    logic [`SDF_CTR_W-1:0] sinc3Mask;
    logic [`SDF_CTR_W-1:0] ratioMask;
    logic                  sinc3Dump;
    logic                  finalDump;
    logic [`SDF_ACC_W-1:0] in1;
    logic [`SDF_ACC_W-1:0] i1n;
    logic [`SDF_ACC_W-1:0] i2n;
    logic [`SDF_ACC_W-1:0] i3n;
    logic [`SDF_ACC_W-1:0] c1;
    logic [`SDF_ACC_W-1:0] c2;
    logic [`SDF_ACC_W-1:0] c3;
    logic [`SDF_OUT_W-1:0] fastIn;
    logic [`SDF_OUT_W-1:0] postIn;

    // Turbo wins over the field; field codes ascend from 128
    function automatic logic [3:0] ratioLog(input logic turbo, input logic [2:0] field);
        ratioLog = turbo ? `SDF_LG_TURBO : `SDF_LG_BASE + {1'b0, field};
    endfunction : ratioLog

    function automatic logic [`SDF_CTR_W-1:0] maskOf(input logic [3:0] lg);
        maskOf = `SDF_CTR_W'((15'h1 << lg) - 15'h1);
    endfunction : maskOf

    function automatic logic [`SDF_SETTLE_W-1:0] settleOf(input logic [3:0] lg);
        unique case (lg)
            4'h6:    settleOf = `SDF_SETTLE_64;
            4'h7:    settleOf = `SDF_SETTLE_128;
            4'h8:    settleOf = `SDF_SETTLE_256;
            4'h9:    settleOf = `SDF_SETTLE_512;
            4'ha:    settleOf = `SDF_SETTLE_1024;
            4'hb:    settleOf = SETTLE_2048;
            4'hc:    settleOf = SETTLE_4096;
            4'hd:    settleOf = SETTLE_8192;
            default: settleOf = SETTLE_16K;
        endcase
    endfunction : settleOf

    // Byte lanes 0 and 1 carry the control bits
    function automatic logic [`SDF_CTRL_W-1:0] mergeCtrl(input logic [`SDF_CTRL_W-1:0] old,
                                                        input logic [31:0] data,
                                                        input logic [3:0] sel);
        mergeCtrl = old;
        if (sel[0]) begin
            mergeCtrl[7:0] = data[7:0];
        end
        if (sel[1]) begin
            mergeCtrl[`SDF_CTRL_W-1:8] = data[`SDF_CTRL_W-1:8];
        end
    endfunction : mergeCtrl

    assign lgRatio   = ratioLog(s_r.ctrl[`SDF_CTRL_TURBO], s_r.ctrl[`SDF_CTRL_RATIO_MSB:`SDF_CTRL_RATIO_LSB]);
    assign lgSinc3   = (lgRatio > `SDF_LG_SINC3_MAX) ? `SDF_LG_SINC3_MAX : lgRatio;
    assign sinc3Mask = maskOf(lgSinc3);
    assign ratioMask = maskOf(lgRatio);
    // Filter state is held clear while the channel is off
    assign clearAll  = s_r.restart || !s_r.ctrl[`SDF_CTRL_ENABLE];
    assign modTick   = (s_r.modPhase == `SDF_MOD_TICK_PHASE);
    assign sinc3Dump = modTick && ((s_r.ctr & sinc3Mask) == sinc3Mask);
    assign finalDump = modTick && (s_r.ctr == ratioMask);

    // One bit maps to plus or minus one
    assign in1 = s_r.modSync2 ? `SDF_ACC_W'(1) : {`SDF_ACC_W{1'b1}};
    // Integrators run at the modulator rate, combs at the sinc3 rate
    assign i1n = s_r.i1 + in1;
    assign i2n = s_r.i2 + i1n;
    assign i3n = s_r.i3 + i2n;
    assign c1  = i3n - s_r.d1;
    assign c2  = c1 - s_r.d2;
    assign c3  = c2 - s_r.d3;

    assign fastIn = {{(`SDF_OUT_W-`SDF_ACC_W){in1[`SDF_ACC_W-1]}}, in1};
    assign postIn = {{(`SDF_OUT_W-`SDF_ACC_W){c3[`SDF_ACC_W-1]}}, c3};

    // Both paths see every modulator bit
    sdf_sinc1_stage u_fast (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clr       (clearAll),
        .inValid   (modTick),
        .inDump    (finalDump),
        .inData    (fastIn),
        .sum       (fastSum),
        .sumStrobe (fastStrobe)
    );

    // At ratios up to 1024 every sinc3 output is also the final dump
    sdf_sinc1_stage u_post (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .clr       (clearAll),
        .inValid   (sinc3Dump),
        .inDump    (finalDump),
        .inData    (postIn),
        .sum       (postSum),
        .sumStrobe (postStrobe)
    );

    always_comb begin
        logic                   req;
        logic                   commit;
        logic [`SDF_CTRL_W-1:0] newCtrl;
        logic [31:0]            status;
        req     = 1'b0;
        commit  = 1'b0;
        newCtrl = '0;
        status  = '0;

        s_nxt           = s_r;
        s_nxt.modSync1  = modBit;
        s_nxt.modSync2  = s_r.modSync1;
        s_nxt.modPhase  = ~s_r.modPhase;
        s_nxt.restart   = 1'b0;
        s_nxt.newSample = 1'b0;

        // Decimation counter and sinc3 integrator/comb state
        if (clearAll) begin
            s_nxt.ctr = '0;
            s_nxt.i1  = '0;
            s_nxt.i2  = '0;
            s_nxt.i3  = '0;
            s_nxt.d1  = '0;
            s_nxt.d2  = '0;
            s_nxt.d3  = '0;
        end else if (modTick) begin
            s_nxt.ctr = finalDump ? '0 : s_r.ctr + `SDF_CTR_W'(1);
            s_nxt.i1  = i1n;
            s_nxt.i2  = i2n;
            s_nxt.i3  = i3n;
            if (sinc3Dump) begin
                s_nxt.d1 = i3n;
                s_nxt.d2 = c1;
                s_nxt.d3 = c2;
            end
        end

        // Settling timer; purely informative, samples are never held back
        if (clearAll) begin
            s_nxt.settleCnt = '0;
            s_nxt.settled   = 1'b0;
        end else if (s_r.settleCnt != settleOf(lgRatio)) begin
            s_nxt.settleCnt = s_r.settleCnt + `SDF_SETTLE_W'(1);
        end else begin
            s_nxt.settled = 1'b1;
        end

        // Fast result is scaled up to the sinc3 gain so both paths line up
        if (postStrobe) begin
            s_nxt.newSample = 1'b1;
            s_nxt.readyN    = 1'b0;
            unique case (s_r.path)
                sdf_pkg::SDF_FAST_FIRST: begin
                    s_nxt.sample = fastSum <<< {lgSinc3, 1'b0};
                    s_nxt.path   = sdf_pkg::SDF_FAST_SECOND;
                end
                sdf_pkg::SDF_FAST_SECOND: begin
                    s_nxt.sample = fastSum <<< {lgSinc3, 1'b0};
                    s_nxt.path   = sdf_pkg::SDF_SINC3;
                end
                sdf_pkg::SDF_SINC3: begin
                    s_nxt.sample = postSum;
                end
                default: begin
                    s_nxt.path = sdf_pkg::SDF_FAST_FIRST;
                end
            endcase
        end

        // Classic Wishbone: ack one cycle after the request, write commits on the ack edge
        req    = wb_cyc_i && wb_stb_i && !s_r.ack;
        commit = wb_cyc_i && wb_stb_i && s_r.ack;
        s_nxt.ack = req;
        status[`SDF_STAT_SINC3]                        = (s_r.path == sdf_pkg::SDF_SINC3);
        status[`SDF_STAT_SETTLED]                      = s_r.settled;
        status[`SDF_STAT_READY_N]                      = s_r.readyN;
        status[`SDF_STAT_CHAN_MSB:`SDF_STAT_CHAN_LSB]  = CHAN_ID;
        status[`SDF_STAT_LG_MSB:`SDF_STAT_LG_LSB]      = lgRatio;
        if (req) begin
            unique case (wb_adr_i[3:2])
                `SDF_IDX_CTRL:   s_nxt.rdata = {{(32-`SDF_CTRL_W){1'b0}}, s_r.ctrl};
                `SDF_IDX_STATUS: s_nxt.rdata = status;
                `SDF_IDX_DATA:   s_nxt.rdata = s_r.sample[`SDF_OUT_W-1:`SDF_OUT_W-32];
                default:         s_nxt.rdata = '0;
            endcase
        end
        if (commit && wb_we_i && wb_adr_i[3:2] == `SDF_IDX_CTRL) begin
            newCtrl = mergeCtrl(s_r.ctrl, wb_dat_i, wb_sel_i);
            // Resync is a command bit and never stored
            s_nxt.ctrl = newCtrl & ~(`SDF_CTRL_W'(1) << `SDF_CTRL_RESYNC);
            s_nxt.restart = newCtrl[`SDF_CTRL_RESYNC]
                || (newCtrl[`SDF_CTRL_ENABLE] && !s_r.ctrl[`SDF_CTRL_ENABLE])
                || (newCtrl[`SDF_CTRL_INSEL_MSB:`SDF_CTRL_INSEL_LSB]
                    != s_r.ctrl[`SDF_CTRL_INSEL_MSB:`SDF_CTRL_INSEL_LSB])
                || (newCtrl[`SDF_CTRL_GAIN_MSB:`SDF_CTRL_GAIN_LSB]
                    != s_r.ctrl[`SDF_CTRL_GAIN_MSB:`SDF_CTRL_GAIN_LSB])
                || (newCtrl[`SDF_CTRL_TURBO:`SDF_CTRL_RATIO_LSB]
                    != s_r.ctrl[`SDF_CTRL_TURBO:`SDF_CTRL_RATIO_LSB]);
        end
        // Reading the data word releases ready, but a new sample in the same cycle wins
        if (commit && !wb_we_i && wb_adr_i[3:2] == `SDF_IDX_DATA && !postStrobe) begin
            s_nxt.readyN = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r           <= '0;
            s_r.ctrl      <= `SDF_CTRL_RESET;
            s_r.path      <= sdf_pkg::SDF_FAST_FIRST;
            s_r.readyN    <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign modClk       = s_r.modPhase;
    assign wb_dat_o     = s_r.rdata;
    assign wb_ack_o     = s_r.ack;
    assign sampleOut    = s_r.sample;
    assign newSample    = s_r.newSample;
    assign sampleReadyN = s_r.readyN;
    assign sinc3Active  = (s_r.path == sdf_pkg::SDF_SINC3);
    assign settled      = s_r.settled;
    assign powerLevel   = s_r.ctrl[`SDF_CTRL_PWR_MSB:`SDF_CTRL_PWR_LSB];

endmodule : sdf_decim_filter

// ---- src/sdf_pkg.sv ----
`include "sdf_consts.svh"

package sdf_pkg;

    typedef enum logic [2:0] {
        SDF_FAST_FIRST  = 3'b001,
        SDF_FAST_SECOND = 3'b010,
        SDF_SINC3       = 3'b100
    } sdf_path_type;

    typedef enum logic [1:0] {
        SDF_HIGH_RESOLUTION_LEVEL  = 2'h0,
        SDF_LOW_POWER_LEVEL        = 2'h1,
        SDF_VERY_LOW_POWER_LEVEL   = 2'h2
    } sdf_power_type;

    typedef struct packed {
        logic [`SDF_OUT_W-1:0] acc;
        logic [`SDF_OUT_W-1:0] sum;
        logic                  strobe;
    } sdf_stage_type;

    typedef struct packed {
        logic                     modSync1;
        logic                     modSync2;
        logic                     modPhase;
        logic [`SDF_CTR_W-1:0]    ctr;
        logic [`SDF_ACC_W-1:0]    i1;
        logic [`SDF_ACC_W-1:0]    i2;
        logic [`SDF_ACC_W-1:0]    i3;
        logic [`SDF_ACC_W-1:0]    d1;
        logic [`SDF_ACC_W-1:0]    d2;
        logic [`SDF_ACC_W-1:0]    d3;
        logic [`SDF_CTRL_W-1:0]   ctrl;
        logic                     restart;
        logic                     ack;
        logic [31:0]              rdata;
        logic [`SDF_SETTLE_W-1:0] settleCnt;
        logic                     settled;
        sdf_path_type             path;
        logic [`SDF_OUT_W-1:0]    sample;
        logic                     newSample;
        logic                     readyN;
    } sdf_state_type;

endpackage : sdf_pkg

// ---- src/sdf_sinc1_stage.sv ----
`timescale 1ns/1ps
`include "sdf_consts.svh"

// First-order sinc: accumulate inputs, dump the sum on the marked input
module sdf_sinc1_stage (
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clr,
    input  wire logic                  inValid,
    input  wire logic                  inDump,
    input  wire logic [`SDF_OUT_W-1:0] inData,
    output      logic [`SDF_OUT_W-1:0] sum,
    output      logic                  sumStrobe
);
    sdf_pkg::sdf_stage_type s_r;
    sdf_pkg::sdf_stage_type s_nxt;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.strobe = 1'b0;
        if (clr) begin
            s_nxt.acc = '0;
        end else if (inValid) begin
            if (inDump) begin
                s_nxt.sum    = s_r.acc + inData;
                s_nxt.acc    = '0;
                s_nxt.strobe = 1'b1;
            end else begin
                s_nxt.acc = s_r.acc + inData;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sum       = s_r.sum;
    assign sumStrobe = s_r.strobe;

endmodule : sdf_sinc1_stage

// ---- test/sdf_decim_filter_chk.sv ----
`timescale 1ns/1ps
`include "sdf_consts.svh"

module sdf_decim_filter_chk (
    input wire logic                  sys_clk,
    input wire logic                  sys_rst,
    input wire logic                  modClk,
    input wire logic [3:0]            wb_adr_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic                  wb_we_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_ack_o,
    input wire logic [`SDF_OUT_W-1:0] sampleOut,
    input wire logic                  newSample,
    input wire logic                  sampleReadyN,
    input wire logic                  sinc3Active,
    input wire logic                  settled
);
    // Saturating strobe count since reset tells the fast path from sinc3
    logic [1:0] nDone_r;
    logic [1:0] nDone_nxt;
    logic [2:0] nNow;

    always_comb begin
        nDone_nxt = nDone_r;
        if (newSample && nDone_r != 2'h3) begin
            nDone_nxt = nDone_r + 2'h1;
        end
    end
    assign nNow = {1'b0, nDone_r} + {2'h0, newSample};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            nDone_r <= 2'h0;
        end else begin
            nDone_r <= nDone_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_resyncReq;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i[3:2] == 2'h0 && wb_sel_i[1] && wb_dat_i[12] && !wb_ack_o;
    endsequence
    sequence s_resyncDone;
        s_resyncReq ##1 wb_ack_o;
    endsequence

    AST_MODCLK_HALF: assert property (!$past(sys_rst) |-> modClk != $past(modClk))
        else $error("modulator clock missed a toggle");
    AST_STROBE_ONE: assert property (newSample |=> !newSample [*8])
        else $error("sample strobe too long");
    AST_READY_WITH_STROBE: assert property (newSample |-> !sampleReadyN)
        else $error("ready not low with new sample");
    AST_READY_CAUSE: assert property ($fell(sampleReadyN) |-> newSample)
        else $error("ready fell without a sample");
    AST_OUT_HELD: assert property (!newSample |-> $stable(sampleOut))
        else $error("sample changed between strobes");
    AST_FAST_FIRST: assert property (nNow < 3'h2 |-> !sinc3Active)
        else $error("sinc3 path before two conversions");
    AST_SINC3_THIRD: assert property (newSample && nDone_r >= 2'h2 |-> sinc3Active)
        else $error("third sample not from sinc3 path");
    AST_SINC3_KEEP: assert property (sinc3Active |=> sinc3Active)
        else $error("left sinc3 path without reset");
    AST_RESYNC_RESTART: assert property (s_resyncDone |-> ##[1:3] !settled)
        else $error("resync did not restart settling");
endmodule : sdf_decim_filter_chk

bind sdf_decim_filter sdf_decim_filter_chk u_chk (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .modClk      (modClk),
    .wb_adr_i    (wb_adr_i),
    .wb_dat_i    (wb_dat_i),
    .wb_sel_i    (wb_sel_i),
    .wb_we_i     (wb_we_i),
    .wb_cyc_i    (wb_cyc_i),
    .wb_stb_i    (wb_stb_i),
    .wb_ack_o    (wb_ack_o),
    .sampleOut   (sampleOut),
    .newSample   (newSample),
    .sampleReadyN(sampleReadyN),
    .sinc3Active (sinc3Active),
    .settled     (settled)
);

// ---- test/sdf_mod_model.sv ----
`timescale 1ns/1ps

// Modulator stand-in: one new bit per modulator tick, on the rising modClk.
// Mode 0 or 1 holds a constant bit, mode 2 gives a three-quarter density.
module sdf_mod_model (
    input  wire logic       sys_clk,
    input  wire logic       modClk,
    input  wire logic [1:0] mode,
    output      logic       modBit
);
    logic       clkPrev_r;
    logic [1:0] sigma_r;

    initial begin
        clkPrev_r = 1'b0;
        sigma_r   = 2'h0;
        modBit    = 1'b0;
    end

    always @(posedge sys_clk) begin
        clkPrev_r <= modClk;
        if (modClk && !clkPrev_r) begin
            sigma_r <= sigma_r + 2'h3;
            modBit  <= mode[1] ? (sigma_r != 2'h0) : mode[0];
        end
    end
endmodule : sdf_mod_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "sdf_consts.svh"

module tb_top;
    logic                  sys_clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic [1:0]            modeSel = 2'h2;
    logic                  modBit;
    logic                  modClk;
    logic [3:0]            adr = 4'h0;
    logic [31:0]           datW = 32'h0;
    logic [3:0]            sel = 4'h0;
    logic                  we = 1'b0;
    logic                  cyc = 1'b0;
    logic                  stb = 1'b0;
    logic [31:0]           datR;
    logic                  ack;
    logic [`SDF_OUT_W-1:0] smp;
    logic                  newSmp;
    logic                  readyN;
    logic                  sinc3On;
    logic                  settled;
    logic [1:0]            pwr;
    logic [31:0]           q;
    int                    fail_count = 0;
    int                    n_checks = 0;
    int                    seed = 32'h6d167ec3;
    int                    c;
    // Settling per log2 ratio; ratios 2048 and up use the shortened count
    int                    settleTab[9] = '{728, 856, 1112, 1624, 2648, 256, 256, 256, 256};

    always #5 sys_clk = ~sys_clk;

    sdf_mod_model u_mod (.sys_clk(sys_clk), .modClk(modClk), .mode(modeSel), .modBit(modBit));

    sdf_decim_filter #(.CHAN_ID(2'h2), .SETTLE_2048(16'h0100), .SETTLE_4096(16'h0100),
                       .SETTLE_8192(16'h0100), .SETTLE_16K(16'h0100)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .modBit(modBit), .modClk(modClk),
        .wb_adr_i(adr), .wb_dat_i(datW), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(datR), .wb_ack_o(ack), .sampleOut(smp), .newSample(newSmp),
        .sampleReadyN(readyN), .sinc3Active(sinc3On), .settled(settled), .powerLevel(pwr));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        datW <= d;
        sel  <= 4'hf;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (ack !== 1'b1 && n < 16);
        q = datR;
        @(posedge sys_clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        chk(n < 16, 1'b1);
    endtask : wb

    task automatic ws();
        c = 0;
        do begin
            @(posedge sys_clk);
            #1;
            c++;
        end while (newSmp !== 1'b1 && c < 40000);
        chk(c < 40000, 1'b1);
    endtask : ws

    function automatic logic [35:0] expv(input int r, input logic lvl);
        longint m;
        longint v;
        m = (r > 1024) ? 1024 : r;
        v = r * m * m;
        return lvl ? 36'(v) : 36'(-v);
    endfunction : expv

    task automatic run_case(input logic [2:0] code, input logic turbo);
        logic [3:0] lg;
        logic [1:0] pw;
        logic       lvl;
        int         r;
        int         n;
        int         seen;
        lg  = turbo ? 4'h6 : 4'h7 + {1'b0, code};
        r   = 1 << lg;
        pw  = 2'($unsigned($random(seed)) % 3);
        lvl = 1'($random(seed));
        @(posedge sys_clk) modeSel <= {1'b0, lvl};
        wb(1'b1, 4'h0, {20'h0, 3'($random(seed)), 2'($random(seed)), 1'b1, pw, turbo, code});
        repeat (2) @(posedge sys_clk);
        #1;
        chk(settled, 1'b0);
        n = 0;
        seen = 0;
        while (settled !== 1'b1 && n < 40000) begin
            @(posedge sys_clk);
            #1;
            n++;
            seen += (newSmp === 1'b1);
        end
        chk(n >= settleTab[lg - 6] - 4 && n <= settleTab[lg - 6] + 4, 1'b1);
        if (settleTab[lg - 6] > 4 * r) chk(seen > 0, 1'b1);
        wb(1'b0, 4'h4, 32'h0);
        chk(q[19:16], lg);
        chk(pwr, pw);
        if (lg <= 4'hb) begin
            repeat (3) ws();
            chk(c, 2 * r);
            chk(smp, expv(r, lvl));
            chk(readyN, 1'b0);
            wb(1'b0, 4'h8, 32'h0);
            chk(q, expv(r, lvl) >> 4);
            #1;
            chk(readyN, 1'b1);
        end
        $display("ratio %0d test done", r);
    endtask : run_case

    initial begin
        // About 37k cycles expected; stop at 80k cycles, well short of the 100k budget
        #800000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wb(1'b0, 4'h0, 32'h0);
        chk(q, 32'h43);
        wb(1'b0, 4'h4, 32'h0);
        chk(q[19:16], 4'ha);
        chk(q[4:3], 2'h2);
        wb(1'b0, 4'hc, 32'h0);
        chk(q, 32'h0);
        ws();
        chk(sinc3On, 1'b0);
        repeat (2) ws();
        chk(sinc3On, 1'b1);
        $display("reset test done");
        for (int i = 0; i < 8; i++) run_case(3'(i), 1'b0);
        wb(1'b1, 4'h0, 32'h8);
        repeat (4) @(posedge sys_clk);
        c = 0;
        repeat (600) begin
            @(posedge sys_clk);
            #1;
            c += (newSmp === 1'b1);
        end
        chk(c, 0);
        run_case(3'($random(seed)), 1'b1);
        wb(1'b0, 4'h0, 32'h0);
        wb(1'b1, 4'h0, q | 32'h1000);
        repeat (2) @(posedge sys_clk);
        #1;
        chk(settled, 1'b0);
        wb(1'b0, 4'h0, 32'h0);
        chk(q[12], 1'b0);
        chk(sinc3On, 1'b1);
        $display("resync test done");
        report_and_stop();
    end
endmodule : tb_top
